/* File: rtl/prr_pkg.sv */
// Constants, register map and carrier types of the pin routing unit.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package prr_pkg;

    localparam int PRR_NUM_IN  = 20;
    localparam int PRR_NUM_PIN = 24;
    localparam int PRR_NUM_SRC = 32;

    // Byte addresses; each register takes one aligned word.
    localparam logic [7:0] PRR_OFS_IN   = 8'h00;
    localparam logic [7:0] PRR_OFS_OUT  = 8'h80;
    localparam logic [7:0] PRR_OFS_LOCK = 8'hE0;
    localparam logic [7:0] PRR_OFS_STAT = 8'hE4;

    localparam logic [7:0] PRR_KEY1 = 8'h55;
    localparam logic [7:0] PRR_KEY2 = 8'hAA;
    localparam int PRR_LOCK_BIT     = 0;
    localparam int PRR_STAT_PERM    = 0;
    localparam int PRR_STAT_CFG     = 1;

    // Output source codes; code zero selects the port latch.
    localparam logic [4:0] PRR_SRC_LAT    = 5'h00;
    localparam logic [4:0] PRR_SRC_CLC1   = 5'h01;
    localparam logic [4:0] PRR_SRC_CLC4   = 5'h04;
    localparam logic [4:0] PRR_SRC_TX1    = 5'h0F;
    localparam logic [4:0] PRR_SRC_DT1    = 5'h10;
    localparam logic [4:0] PRR_SRC_TX2    = 5'h11;
    localparam logic [4:0] PRR_SRC_DT2    = 5'h12;
    localparam logic [4:0] PRR_SRC_SCK    = 5'h15;
    localparam logic [4:0] PRR_SRC_SDA    = 5'h16;
    localparam logic [4:0] PRR_SRC_REFCLK = 5'h1B;

    // Pin code = port index * 8 + bit; set bits mark pins that exist.
    localparam logic [23:0] PRR_PINS_20 = 24'hFFF03F;
    localparam logic [23:0] PRR_PINS_14 = 24'h3F003F;

    // Power-on input selections, entry 19 first.
    localparam logic [19:0][4:0] PRR_IN_SEL_RST = {
        5'h10, 5'h11, 5'h0F, 5'h0D, 5'h16, 5'h0C, 5'h0E, 5'h12,
        5'h0D, 5'h0C, 5'h13, 5'h02, 5'h02, 5'h13, 5'h15, 5'h05,
        5'h04, 5'h05, 5'h02, 5'h02};

    typedef enum logic [1:0] {
        PRR_SEQ_IDLE,
        PRR_SEQ_KEY1,
        PRR_SEQ_OPEN
    } prr_seq_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } prr_wb_req_t;

    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
    } prr_wb_rsp_t;

    typedef struct packed {
        logic [19:0][4:0] in_sel;
        logic [23:0][4:0] out_sel;
        logic             lock;
        logic             perm;
        prr_seq_t         seq;
        logic             ack;
        logic [7:0]       rdata;
        logic [23:0]      sync1;
        logic [23:0]      sync2;
        logic [19:0]      periph_in;
        logic [23:0]      pin_out;
        logic [23:0]      pin_oe_n;
    } prr_state_t;

endpackage

/* File: rtl/prr_router.sv */
// Digital pin routing matrix with a Wishbone register slave.
// Assumes pins arrive asynchronously; port direction, port latch,
// analog select and peripheral signals come from logic on clk_i.
`timescale 1ns/10ps

// Summary of operation
// RULE1: The unit steers digital peripheral signals to and from pins.
// RULE2: Analog functions never pass through the unit and keep their pins.
// RULE3: Input and output selectors are written independently.
// RULE4: Every peripheral input has its own selector with one encoding.
// RULE5: Every pin has its own output selector with one source encoding.
// RULE6: The pin direction bit enables the driver unless a peripheral does.
// RULE7: Synchronous serial and two-wire modes take over pin direction.
// RULE8: An input code is port index times eight plus the bit number.
// RULE9: Power-on loads each input selector with its default pin code.
// RULE10: A code for a pin that is not built feeds a constant low.
// RULE11: Power-on resets selections and lock; other resets keep them. The code keeps selections but clears the lock on dev_rst_i.
// RULE12: The lock bit changes only after 0x55 then 0xAA; locked blocks.
// RULE13: With the one-way option, setting the lock holds it until reset.
// RULE14: Source codes 0x01-0x04 are logic cells and 0x1B the ref clock.
module prr_router #(
    parameter bit HAS_PORTB = 1'b1
) (
    // Clock and resets
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  dev_rst_i,
    // Register bus
    input  wire prr_pkg::prr_wb_req_t  wb_req_i,
    output      prr_pkg::prr_wb_rsp_t  wb_rsp_o,
    // Configuration
    input  wire logic                  one_shot_lock_cfg_i,
    // Port control
    input  wire logic [23:0]           pin_direction_bit_i,
    input  wire logic [23:0]           port_latch_i,
    input  wire logic [23:0]           pin_analog_i,
    // Peripheral side
    input  wire logic [31:0]           periph_out_i,
    input  wire logic [31:0]           periph_drv_n_i,
    input  wire logic [1:0]            uart_sync_mode_i,
    input  wire logic                  ssp_two_wire_mode_i,
    output      logic [19:0]           periph_in_o,
    // Pins
    input  wire logic [23:0]           pin_i,
    output      logic [23:0]           pin_o,
    output      logic [23:0]           pin_oe_n_o
);

    localparam logic [31:0] PRESENT =
        {8'h00, HAS_PORTB ? prr_pkg::PRR_PINS_20 : prr_pkg::PRR_PINS_14};

    prr_pkg::prr_state_t st;
    prr_pkg::prr_state_t next_st;

    logic        wr;
    logic [5:0]  idx;
    logic [31:0] vis;

    // Level seen by the input selectors at a pin code.
    function automatic logic pin_level(input logic [4:0]  code,
                                       input logic [31:0] lv);
        pin_level = PRESENT[code] & lv[code]; // RULE10
    endfunction

    // True when the source drives its own output enable.
    function automatic logic drives_oe(input logic [4:0] src,
                                       input logic [1:0] usync,
                                       input logic       twi);
        drives_oe = ((src == prr_pkg::PRR_SRC_TX1 ||
                      src == prr_pkg::PRR_SRC_DT1) && usync[0]) ||
                    ((src == prr_pkg::PRR_SRC_TX2 ||
                      src == prr_pkg::PRR_SRC_DT2) && usync[1]) ||
                    ((src == prr_pkg::PRR_SRC_SCK ||
                      src == prr_pkg::PRR_SRC_SDA) && twi);
    endfunction

    function automatic logic is_in(input logic [5:0] i);
        is_in = i < 6'(prr_pkg::PRR_NUM_IN);
    endfunction

    function automatic logic is_out(input logic [5:0] i);
        is_out = (i >= prr_pkg::PRR_OFS_OUT[7:2]) &&
                 (i < prr_pkg::PRR_OFS_OUT[7:2] + 6'(prr_pkg::PRR_NUM_PIN));
    endfunction

    assign idx = wb_req_i.adr[7:2];
    assign wr  = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & st.ack &
                 wb_req_i.sel[0];
    // Analog pins have no digital input buffer.
    assign vis = {8'h00, st.sync2 & ~pin_analog_i}; // RULE2

    always_comb begin
        next_st = st;
        next_st.sync1 = pin_i;
        next_st.sync2 = st.sync1;
        // One-cycle ack, dropped after it was given.
        next_st.ack = wb_req_i.cyc & wb_req_i.stb & ~st.ack;
        next_st.rdata = 8'h00;
        if (is_in(idx)) begin
            next_st.rdata = {3'h0, st.in_sel[5'(idx)]};
        end else if (is_out(idx)) begin
            next_st.rdata =
                {3'h0, st.out_sel[5'(idx - prr_pkg::PRR_OFS_OUT[7:2])]};
        end else if (idx == prr_pkg::PRR_OFS_LOCK[7:2]) begin
            next_st.rdata[prr_pkg::PRR_LOCK_BIT] = st.lock;
        end else if (idx == prr_pkg::PRR_OFS_STAT[7:2]) begin
            next_st.rdata[prr_pkg::PRR_STAT_PERM] = st.perm;
            next_st.rdata[prr_pkg::PRR_STAT_CFG]  = one_shot_lock_cfg_i;
        end

        if (wr) begin
            // Any other write breaks the unlock sequence.
            next_st.seq = prr_pkg::PRR_SEQ_IDLE;
            if (is_in(idx) && !st.lock) begin
                next_st.in_sel[5'(idx)] = wb_req_i.dat[4:0]; // RULE4
            end
            if (is_out(idx) && !st.lock) begin
                next_st.out_sel[5'(idx - prr_pkg::PRR_OFS_OUT[7:2])] =
                    wb_req_i.dat[4:0]; // RULE5
            end
            if (idx == prr_pkg::PRR_OFS_LOCK[7:2]) begin
                unique case (st.seq)
                    prr_pkg::PRR_SEQ_IDLE: begin
                        if (wb_req_i.dat[7:0] == prr_pkg::PRR_KEY1) begin
                            next_st.seq = prr_pkg::PRR_SEQ_KEY1; // RULE12
                        end
                    end
                    prr_pkg::PRR_SEQ_KEY1: begin
                        if (wb_req_i.dat[7:0] == prr_pkg::PRR_KEY2) begin
                            next_st.seq = prr_pkg::PRR_SEQ_OPEN; // RULE12
                        end else if (wb_req_i.dat[7:0] ==
                                     prr_pkg::PRR_KEY1) begin
                            next_st.seq = prr_pkg::PRR_SEQ_KEY1;
                        end
                    end
                    prr_pkg::PRR_SEQ_OPEN: begin
                        if (wb_req_i.dat[prr_pkg::PRR_LOCK_BIT]) begin
                            next_st.lock = 1'b1; // RULE12
                            if (one_shot_lock_cfg_i) begin
                                next_st.perm = 1'b1; // RULE13
                            end
                        end else if (!st.perm) begin
                            next_st.lock = 1'b0; // RULE13
                        end
                    end
                endcase
            end
        end

        // Input side reads only in_sel, output side only out_sel.
        for (int k = 0; k < prr_pkg::PRR_NUM_IN; k++) begin // RULE3
            next_st.periph_in[k] = pin_level(st.in_sel[k], vis); // RULE8
        end
        for (int p = 0; p < prr_pkg::PRR_NUM_PIN; p++) begin
            if (st.out_sel[p] == prr_pkg::PRR_SRC_LAT) begin
                next_st.pin_out[p] = PRESENT[p] & port_latch_i[p]; // RULE1
            end else begin
                next_st.pin_out[p] =
                    PRESENT[p] & periph_out_i[st.out_sel[p]]; // RULE14
            end
            if (drives_oe(st.out_sel[p], uart_sync_mode_i,
                          ssp_two_wire_mode_i)) begin
                next_st.pin_oe_n[p] =
                    ~PRESENT[p] | periph_drv_n_i[st.out_sel[p]]; // RULE7
            end else begin
                next_st.pin_oe_n[p] =
                    ~PRESENT[p] | pin_direction_bit_i[p]; // RULE6
            end
        end

        // A non-power-on reset clears the lock but keeps selections.
        if (dev_rst_i) begin
            next_st.lock = 1'b0; // RULE11
            next_st.perm = 1'b0;
            next_st.seq  = prr_pkg::PRR_SEQ_IDLE;
        end
        if (rst_i) begin
            next_st          = '0;
            next_st.in_sel   = prr_pkg::PRR_IN_SEL_RST; // RULE9
            next_st.pin_oe_n = '1; // RULE11
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    assign wb_rsp_o.ack = st.ack;
    assign wb_rsp_o.dat = {24'h000000, st.rdata};
    assign periph_in_o  = st.periph_in;
    assign pin_o        = st.pin_out;
    assign pin_oe_n_o   = st.pin_oe_n;

    // Checks. Pins 0, 2, 3 and 6 and input entry 0 stand for all of their kind.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic sel_wr;
    assign sel_wr = wr & (is_in(idx) | is_out(idx));

    localparam logic [5:0] LOCK_IDX = prr_pkg::PRR_OFS_LOCK[7:2];
    localparam logic [5:0] STAT_IDX = prr_pkg::PRR_OFS_STAT[7:2];
    localparam logic [5:0] OUT2_IDX = prr_pkg::PRR_OFS_OUT[7:2] + 6'h02;
    // A word between the status register and the top of the map.
    localparam logic [5:0] HOLE_IDX = 6'h3C;

    logic lock_wr;
    logic bus_req;
    assign lock_wr = wr & (idx == LOCK_IDX);
    assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~st.ack;

    sequence key1_wr_s;
        lock_wr && !dev_rst_i && st.seq == prr_pkg::PRR_SEQ_IDLE &&
        wb_req_i.dat[7:0] == prr_pkg::PRR_KEY1;
    endsequence

    sequence key2_wr_s;
        lock_wr && !dev_rst_i && st.seq == prr_pkg::PRR_SEQ_KEY1 &&
        wb_req_i.dat[7:0] == prr_pkg::PRR_KEY2;
    endsequence

    sequence open_wr_s;
        lock_wr && !dev_rst_i && st.seq == prr_pkg::PRR_SEQ_OPEN;
    endsequence

    sequence unlock_s;
        $past(st.seq) == prr_pkg::PRR_SEQ_OPEN;
    endsequence

    sequence lock_moved_s;
        $changed(st.lock) && !$past(dev_rst_i) && !$past(rst_i);
    endsequence

    por_defaults_a: assert property ( // RULE9
        $past(rst_i) |-> st.in_sel == prr_pkg::PRR_IN_SEL_RST &&
                         !st.lock && st.out_sel == '0)
        else $error("selectors not at power-on defaults");

    locked_hold_a: assert property ( // RULE12
        (sel_wr && st.lock && !dev_rst_i) |=>
            $stable(st.in_sel) && $stable(st.out_sel))
        else $error("selector changed while locked");

    lock_key_a: assert property ( // RULE12
        lock_moved_s |-> unlock_s)
        else $error("lock bit moved without unlock sequence");

    perm_hold_a: assert property ( // RULE13
        (st.perm && !dev_rst_i) |=> st.lock && st.perm)
        else $error("permanent lock released");

    dev_keep_a: assert property ( // RULE11
        dev_rst_i |=> $stable(st.in_sel) && $stable(st.out_sel) &&
                      !st.lock)
        else $error("device reset disturbed selections");

    in_indep_a: assert property ( // RULE3
        (wr && is_in(idx)) |=> $stable(st.out_sel))
        else $error("input write changed an output selector");

    in_route_a: assert property ( // RULE8
        ##1 periph_in_o[0] == $past(pin_level(st.in_sel[0], vis)))
        else $error("peripheral input not fed by selected pin");

    absent_low_a: assert property ( // RULE10
        !PRESENT[st.in_sel[0]] |=> !periph_in_o[0])
        else $error("absent pin code did not give low");

    latch_out_a: assert property ( // RULE5
        st.out_sel[0] == prr_pkg::PRR_SRC_LAT |=>
            pin_o[0] == $past(port_latch_i[0]))
        else $error("pin data not from port latch");

    dir_keep_a: assert property ( // RULE6
        !drives_oe(st.out_sel[0], uart_sync_mode_i,
                   ssp_two_wire_mode_i) |=>
            pin_oe_n_o[0] == $past(pin_direction_bit_i[0]))
        else $error("direction bit did not steer driver");

    dir_ovr_a: assert property ( // RULE7
        (uart_sync_mode_i[0] && st.out_sel[3] == prr_pkg::PRR_SRC_TX1)
            |=> pin_oe_n_o[3] ==
                $past(periph_drv_n_i[prr_pkg::PRR_SRC_TX1]))
        else $error("serial port did not take over driver");

    ack_pulse_a: assert property (
        wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");

    ack_answer_a: assert property (
        bus_req |=> wb_rsp_o.ack)
        else $error("request not answered in one cycle");

    out_indep_a: assert property ( // RULE3
        (wr && is_out(idx)) |=> $stable(st.in_sel))
        else $error("output write changed an input selector");

    rd_data_a: assert property ( // RULE4
        (bus_req && !wb_req_i.we && idx == 6'h00) |=>
            wb_rsp_o.dat == {27'h0000000, $past(st.in_sel[0])})
        else $error("read data not the input selector");

    in_write_a: assert property ( // RULE4
        (wr && idx == 6'h00 && !st.lock) |=>
            st.in_sel[0] == $past(wb_req_i.dat[4:0]))
        else $error("input selector write lost");

    out_write_a: assert property ( // RULE5
        (wr && idx == OUT2_IDX && !st.lock) |=>
            st.out_sel[2] == $past(wb_req_i.dat[4:0]))
        else $error("output selector write lost");

    key1_step_a: assert property ( // RULE12
        key1_wr_s |=> st.seq == prr_pkg::PRR_SEQ_KEY1)
        else $error("first key not taken");

    key2_step_a: assert property ( // RULE12
        key2_wr_s |=> st.seq == prr_pkg::PRR_SEQ_OPEN)
        else $error("second key not taken");

    seq_break_a: assert property ( // RULE12
        (wr && idx != LOCK_IDX && !dev_rst_i) |=>
            st.seq == prr_pkg::PRR_SEQ_IDLE)
        else $error("other write did not break unlock sequence");

    lock_set_a: assert property ( // RULE12
        open_wr_s ##0 wb_req_i.dat[0] |=> st.lock)
        else $error("lock bit not set after unlock sequence");

    lock_clear_a: assert property ( // RULE12
        open_wr_s ##0 (!wb_req_i.dat[0] && !st.perm) |=> !st.lock)
        else $error("lock bit not cleared after unlock sequence");

    perm_set_a: assert property ( // RULE13
        open_wr_s ##0 (wb_req_i.dat[0] && one_shot_lock_cfg_i) |=> st.perm)
        else $error("one-way lock not made permanent");

    dev_clear_a: assert property ( // RULE11
        dev_rst_i |=> !st.perm && st.seq == prr_pkg::PRR_SEQ_IDLE)
        else $error("device reset left lock state");

    por_pins_a: assert property ( // RULE11
        $past(rst_i) |-> pin_oe_n_o == '1 && pin_o == '0)
        else $error("pins not released after power-on");

    analog_zero_a: assert property ( // RULE2
        (st.in_sel[0] == 5'h13 && pin_analog_i[19]) |=> !periph_in_o[0])
        else $error("analog pin reached a peripheral input");

    absent_out_a: assert property ( // RULE1
        1'b1 |=> !pin_o[6] && pin_oe_n_o[6])
        else $error("absent pin driven");

    cell_out_a: assert property ( // RULE14
        st.out_sel[2] == prr_pkg::PRR_SRC_CLC1 |=>
            pin_o[2] == $past(periph_out_i[prr_pkg::PRR_SRC_CLC1]))
        else $error("logic cell output not on pin");

    refclk_out_a: assert property ( // RULE14
        st.out_sel[2] == prr_pkg::PRR_SRC_REFCLK |=>
            pin_o[2] == $past(periph_out_i[prr_pkg::PRR_SRC_REFCLK]))
        else $error("reference clock not on pin");

    twi_ovr_a: assert property ( // RULE7
        (ssp_two_wire_mode_i && st.out_sel[3] == prr_pkg::PRR_SRC_SDA) |=>
            pin_oe_n_o[3] == $past(periph_drv_n_i[prr_pkg::PRR_SRC_SDA]))
        else $error("two-wire port did not take over driver");

    hole_read_a: assert property ( // RULE1
        (bus_req && idx == HOLE_IDX) |=> wb_rsp_o.dat == 32'h00000000)
        else $error("unmapped read not zero");

    stat_read_a: assert property ( // RULE13
        (bus_req && idx == STAT_IDX) |=>
            wb_rsp_o.dat[1] == $past(one_shot_lock_cfg_i))
        else $error("status does not show one-way option");

endmodule

/* File: tb/prr_periph_model.sv */
// Peripheral-side stand-in for the pin router bench.
// Assumes the bench sets the wanted output pattern; values move on clk_i.
`timescale 1ns/10ps
module prr_periph_model (
    // Clock
    input  wire logic        clk_i,
    // Bench control
    input  wire logic [31:0] pat_i,
    input  wire logic [31:0] drv_n_i,
    // Router side
    output      logic [31:0] periph_out_o,
    output      logic [31:0] periph_drv_n_o
);
    // Outputs change only after an edge, as real peripheral flops do.
    always_ff @(posedge clk_i) begin
        periph_out_o   <= pat_i;
        periph_drv_n_o <= drv_n_i;
    end
endmodule

/* File: tb/prr_router_bench.sv */
// Self-checking bench for the pin routing unit.
// Assumes the router answers Wishbone cycles and pins settle in 3 edges.
`timescale 1ns/10ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %0t %s", $time, m); end end
module prr_router_bench;
    logic                 clk_i, rst_i, dev_rst_i, cfg, twi;
    logic [23:0]          dir, lat, ana, pin, pin_o, oe_n;
    logic [31:0]          pat, drv_n, p_out, p_drv_n;
    logic [1:0]           usync;
    logic [19:0]          p_in;
    prr_pkg::prr_wb_req_t req;
    prr_pkg::prr_wb_rsp_t rsp;
    int                   n_fail, n_checks;
    logic [7:0]           rst_tab [20] = '{8'h02, 8'h02, 8'h05, 8'h04,
        8'h05, 8'h15, 8'h13, 8'h02, 8'h02, 8'h13, 8'h0C, 8'h0D, 8'h12,
        8'h0E, 8'h0C, 8'h16, 8'h0D, 8'h0F, 8'h11, 8'h10};

    prr_router u_prr_router (.clk_i(clk_i), .rst_i(rst_i),
        .dev_rst_i(dev_rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .one_shot_lock_cfg_i(cfg), .pin_direction_bit_i(dir),
        .port_latch_i(lat), .pin_analog_i(ana), .periph_out_i(p_out),
        .periph_drv_n_i(p_drv_n), .uart_sync_mode_i(usync),
        .ssp_two_wire_mode_i(twi), .periph_in_o(p_in), .pin_i(pin),
        .pin_o(pin_o), .pin_oe_n_o(oe_n));
    prr_periph_model u_prr_periph_model (.clk_i(clk_i), .pat_i(pat),
        .drv_n_i(drv_n), .periph_out_o(p_out), .periph_drv_n_o(p_drv_n));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1,
                 dat: {24'h000000, d}};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        q = rsp.dat[7:0];
        req <= '0;
        if (n >= 20) begin
            n_fail++;
            $display("MISMATCH %0t bus timeout", $time);
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        `CHK(q, e, "read value")
    endtask

    task automatic lock(input logic [7:0] v);
        wr(8'hE0, 8'h55);
        wr(8'hE0, 8'hAA);
        wr(8'hE0, v);
    endtask

    task automatic settle();
        repeat (4) @(posedge clk_i);
    endtask

    initial begin
        n_fail = 0; n_checks = 0; rst_i = 1'b1; dev_rst_i = 1'b0;
        cfg = 1'b0; twi = 1'b0; usync = 2'h0; dir = '1; lat = 24'h000001;
        ana = '0; pin = '0; pat = '0; drv_n = '1; req = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 20; k++) begin
            rd(8'(4 * k), rst_tab[k]);
        end
        rd(8'h88, 8'h00);
        rd(8'hF0, 8'h00);
        `CHK(pin_o[0], 1'b1, "latch on pin")
        $display("test reset values done");
        wr(8'h00, 8'hF3);
        rd(8'h00, 8'h13);
        pin[19] <= 1'b1;
        settle();
        `CHK(p_in[0], 1'b1, "routed input")
        ana[19] <= 1'b1;
        settle();
        `CHK(p_in[0], 1'b0, "analog pin")
        ana <= '0;
        pin <= '1;
        wr(8'h00, 8'h08);
        settle();
        `CHK(p_in[0], 1'b0, "absent pin")
        $display("test input routing done");
        wr(8'h88, 8'h01);
        pat <= 32'h00000002;
        dir[2] <= 1'b0;
        settle();
        `CHK(pin_o[2], 1'b1, "cell output")
        `CHK(oe_n[2], 1'b0, "driver on")
        dir[2] <= 1'b1;
        wr(8'h88, 8'h1B);
        pat <= 32'h08000000;
        settle();
        `CHK(oe_n[2], 1'b1, "driver off")
        `CHK(pin_o[2], 1'b1, "ref clock")
        rd(8'h00, 8'h08);
        wr(8'h8C, 8'h0F);
        drv_n <= ~32'h00008000;
        usync <= 2'h1;
        settle();
        `CHK(oe_n[3], 1'b0, "sync takes pin")
        usync <= 2'h0;
        settle();
        `CHK(oe_n[3], 1'b1, "direction back")
        wr(8'h8C, 8'h16);
        drv_n <= ~32'h00400000;
        twi <= 1'b1;
        settle();
        `CHK(oe_n[3], 1'b0, "two-wire takes pin")
        $display("test output routing done");
        lock(8'h01);
        rd(8'hE0, 8'h01);
        wr(8'h00, 8'h05);
        rd(8'h00, 8'h08);
        lock(8'h00);
        wr(8'h00, 8'h05);
        rd(8'h00, 8'h05);
        cfg <= 1'b1;
        lock(8'h01);
        lock(8'h00);
        rd(8'hE0, 8'h01);
        rd(8'hE4, 8'h03);
        $display("test lock done");
        dev_rst_i <= 1'b1;
        @(posedge clk_i);
        dev_rst_i <= 1'b0;
        rd(8'hE0, 8'h00);
        rd(8'h00, 8'h05);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h00, 8'h02);
        rd(8'h8C, 8'h00);
        $display("test resets done");
        end_of_test();
    end
endmodule
